// file: rtl/ucpc_pkg.sv
// package: register map, field positions, reset values and encodings for usb clock/phy control
package ucpc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [3:0] UCPC_OFF_LINE = 4'h0;
  localparam logic [3:0] UCPC_OFF_PLL = 4'h4;
  localparam logic [3:0] UCPC_OFF_XCVR = 4'h8;
  localparam logic [3:0] UCPC_OFF_STAT = 4'hC;
  // ==========================================================
  // line/clock control fields
  localparam int UCPC_LINE_GATE_BIT = 0;
  localparam int UCPC_LINE_ATTACH_BIT = 1;
  localparam logic [7:0] UCPC_LINE_RESET = 8'h00;
  // ==========================================================
  // pll source control fields
  localparam int UCPC_PLL_FLO_LSB = 0;
  localparam int UCPC_PLL_SRC_LSB = 2;
  localparam int UCPC_PLL_FHI_BIT = 5;
  localparam logic [7:0] UCPC_PLL_RESET = 8'h01;
  // ==========================================================
  // transceiver control fields
  localparam int UCPC_XCVR_SEL_BIT = 0;
  localparam int UCPC_XCVR_SUSP_BIT = 1;
  localparam logic [7:0] UCPC_XCVR_RESET = 8'h00;
  // ==========================================================
  // status fields
  localparam int UCPC_STAT_GATE_BIT = 0;
  localparam int UCPC_STAT_RUN_BIT = 1;
  localparam int UCPC_STAT_BYP_BIT = 2;
  localparam int UCPC_STAT_REF_BIT = 3;
  // ==========================================================
  // source select encodings
  localparam logic [2:0] UCPC_SRC_BYPASS = 3'h5;
  localparam logic [2:0] UCPC_SRC_CRYSTAL = 3'h6;
  localparam logic [2:0] UCPC_SRC_EXT = 3'h7;
  // reference frequency encodings
  localparam logic [2:0] UCPC_FREF_8M = 3'h0;
  localparam logic [2:0] UCPC_FREF_12M = 3'h1;
  localparam logic [2:0] UCPC_FREF_16M = 3'h2;
  localparam logic [2:0] UCPC_FREF_20M = 3'h3;
  localparam logic [2:0] UCPC_FREF_24M = 3'h4;
endpackage

// file: rtl/ucpc_top.sv
// usb clock and phy control: ahb-lite registers, pll source control, clock gate, pin muxing
`timescale 1ns/100ps
// Behaviour
// [RULE1] reserved register bits read zero, ignore writes
// [RULE2] detached: both data pins high impedance
// [RULE3] attached: pull-up plus, pull-down minus
// [RULE4] cable power sensing done outside by system
// [RULE5] gate bit blocks or passes core clock
// [RULE6] software gates clock before stopping pll
// [RULE7] source 0XX stops pll, no input
// [RULE8] source encoding 100 never written
// [RULE9] source 101 bypasses pll with pin clock
// [RULE10] source 110 runs pll from crystal
// [RULE11] source 111 runs pll from pin clock
// [RULE12] pll makes 48 MHz from declared reference
// [RULE13] frequency codes 8,12,16,20,24 MHz
// [RULE14] software writes only defined frequency codes
// [RULE15] frequency field from bits 5,1,0
// [RULE16] pll register resets to 0x01
// [RULE17] transceiver mode routes rx in, tx out
// [RULE18] transceiver speed output held high
// [RULE19] select bit picks internal or transceiver path
// [RULE20] line register resets to 0x00
// [RULE21] software releases recovery reset after settling
// [RULE22] gate changes only while source clock low
module ucpc_top
  import ucpc_pkg::*;
(
  input wire logic core_clk, // 50 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, word only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  output logic [31:0] hrdata, // ahb read data
  input wire logic ext_usb_clock_pin, // external usb clock pin
  input wire logic pll_clk_in, // 48 MHz output of the pll
  output logic pll_run, // pll enabled
  output logic pll_ref_ext, // pll reference: 1 pin clock, 0 crystal
  output logic [2:0] pll_ref_freq_select, // declared reference frequency
  output logic usb_core_clk, // gated core clock, sampled form
  output logic core_clock_gate_on, // gate currently passing clock
  input wire logic core_tx_plus, // core transmit plus
  input wire logic core_tx_minus, // core transmit minus
  input wire logic core_tx_oe_n, // core transmit enable, low active
  input wire logic core_suspend, // core suspend request
  output logic core_rx_plus, // received plus to core
  output logic core_rx_minus, // received minus to core
  output logic core_rx_data, // received differential data to core
  input wire logic data_plus_pin_in, // internal plus pin level
  output logic data_plus_pin_out, // internal plus pin drive value
  output logic data_plus_pin_oe, // internal plus pin drive enable
  input wire logic data_minus_pin_in, // internal minus pin level
  output logic data_minus_pin_out, // internal minus pin drive value
  output logic data_minus_pin_oe, // internal minus pin drive enable
  output logic data_plus_pullup_en, // pull-up on plus pin
  output logic data_minus_pulldown_en, // pull-down on minus pin
  input wire logic rx_plus_in, // transceiver plus input
  input wire logic rx_minus_in, // transceiver minus input
  input wire logic rx_diff_data, // transceiver data input
  output logic tx_plus_out, // transceiver plus output
  output logic tx_minus_out, // transceiver minus output
  output logic tx_output_enable_n, // transceiver output enable, low active
  output logic xcvr_suspend, // transceiver suspend
  output logic xcvr_speed // transceiver speed select
);
  // ==========================================================
  // state
  typedef struct packed {
    logic attach;
    logic gate;
    logic fhi;
    logic [2:0] src;
    logic [1:0] flo;
    logic xsel;
    logic xsusp;
    logic ph_wr;
    logic ph_rd;
    logic [3:0] ph_addr;
    logic [7:0] rdat;
    logic [1:0] ext_s;
    logic [1:0] pllc_s;
    logic [1:0] rxp_s;
    logic [1:0] rxm_s;
    logic [1:0] rxd_s;
    logic [1:0] dp_s;
    logic [1:0] dm_s;
    logic gate_on;
    logic clk_o;
    logic rxp;
    logic rxm;
    logic rxd;
    logic dp_o;
    logic dp_e;
    logic dm_o;
    logic dm_e;
    logic pu;
    logic pd;
    logic txp;
    logic txm;
    logic txe_n;
    logic susp;
  } ucpc_state_s;

  ucpc_state_s st;
  ucpc_state_s next_st;
  logic [7:0] line_reg;
  logic [7:0] pll_reg;
  logic [7:0] xcvr_reg;
  logic [7:0] stat_reg;
  logic addr_phase;
  logic src_level;
  logic bypass;

  // [RULE1] reserved bits zero
  assign line_reg = {6'h00, st.attach, st.gate};
  assign pll_reg = {2'h0, st.fhi, st.src, st.flo};
  assign xcvr_reg = {6'h00, st.xsusp, st.xsel};
  assign stat_reg = {4'h0, pll_ref_ext, bypass, pll_run, st.gate_on};
  assign addr_phase = hsel && htrans[1] && hready;
  assign bypass = (st.src == UCPC_SRC_BYPASS);
  // [RULE9] pin clock used directly in bypass
  assign src_level = bypass ? st.ext_s[1] : st.pllc_s[1];

  // ==========================================================
  // bus slave: zero wait, okay only
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // read word loaded at the address phase, so hrdata comes straight from a flop;
  // a read right behind a write to the same register still sees the old value
  assign hrdata = {24'h00_0000, st.rdat};

  // ==========================================================
  // pll control
  // [RULE7] 0XX stops pll
  // [RULE10] 110 runs from crystal
  // [RULE11] 111 runs from pin clock
  assign pll_run = st.src[2] && st.src[1];
  assign pll_ref_ext = pll_run && st.src[0];
  // [RULE12] [RULE13] [RULE15] frequency field assembly
  assign pll_ref_freq_select = {st.fhi, st.flo};

  always_comb begin
    next_st = st;
    next_st.ph_wr = addr_phase && hwrite;
    next_st.ph_rd = addr_phase && !hwrite;
    next_st.ph_addr = addr_phase ? haddr[3:0] : st.ph_addr;
    // zero outside a read data phase
    next_st.rdat = 8'h00;
    if (addr_phase && !hwrite) begin
      case (haddr[3:0])
        UCPC_OFF_LINE: next_st.rdat = line_reg;
        UCPC_OFF_PLL: next_st.rdat = pll_reg;
        UCPC_OFF_XCVR: next_st.rdat = xcvr_reg;
        UCPC_OFF_STAT: next_st.rdat = stat_reg;
        default: next_st.rdat = 8'h00;
      endcase
    end
    if (st.ph_wr) begin
      case (st.ph_addr)
        UCPC_OFF_LINE: begin
          next_st.gate = hwdata[UCPC_LINE_GATE_BIT];
          next_st.attach = hwdata[UCPC_LINE_ATTACH_BIT];
        end
        UCPC_OFF_PLL: begin
          next_st.flo = hwdata[UCPC_PLL_FLO_LSB +: 2];
          next_st.src = hwdata[UCPC_PLL_SRC_LSB +: 3];
          next_st.fhi = hwdata[UCPC_PLL_FHI_BIT];
        end
        UCPC_OFF_XCVR: begin
          next_st.xsel = hwdata[UCPC_XCVR_SEL_BIT];
          next_st.xsusp = hwdata[UCPC_XCVR_SUSP_BIT];
        end
        default: next_st.gate = st.gate;
      endcase
    end
    // pin and clock inputs through two flops
    next_st.ext_s = {st.ext_s[0], ext_usb_clock_pin};
    next_st.pllc_s = {st.pllc_s[0], pll_clk_in};
    next_st.rxp_s = {st.rxp_s[0], rx_plus_in};
    next_st.rxm_s = {st.rxm_s[0], rx_minus_in};
    next_st.rxd_s = {st.rxd_s[0], rx_diff_data};
    next_st.dp_s = {st.dp_s[0], data_plus_pin_in};
    next_st.dm_s = {st.dm_s[0], data_minus_pin_in};
    // [RULE22] gate follows bit only while source low
    if (!src_level) begin
      next_st.gate_on = st.gate;
    end
    // [RULE5] clock passes only when gate on; stopped pll gives no clock
    next_st.clk_o = st.gate_on && src_level && (pll_run || bypass);
    // [RULE19] path select
    if (st.xsel) begin
      next_st.rxp = st.rxp_s[1];
      next_st.rxm = st.rxm_s[1];
      next_st.rxd = st.rxd_s[1];
    end else begin
      next_st.rxp = st.dp_s[1];
      next_st.rxm = st.dm_s[1];
      next_st.rxd = st.dp_s[1] && !st.dm_s[1];
    end
    // [RULE2] detached or external path: pins floating
    next_st.dp_e = st.attach && !st.xsel && !core_tx_oe_n;
    next_st.dm_e = st.attach && !st.xsel && !core_tx_oe_n;
    next_st.dp_o = core_tx_plus;
    next_st.dm_o = core_tx_minus;
    // [RULE3] attach applies pulls
    next_st.pu = st.attach;
    next_st.pd = st.attach;
    // [RULE17] transceiver outputs; idle disabled when not selected
    next_st.txp = st.xsel && core_tx_plus;
    next_st.txm = st.xsel && core_tx_minus;
    next_st.txe_n = !(st.xsel && !core_tx_oe_n);
    next_st.susp = st.xsel && (core_suspend || st.xsusp);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
      // [RULE20] line register reset value
      {st.attach, st.gate} <= UCPC_LINE_RESET[1:0];
      // [RULE16] pll register reset value
      {st.fhi, st.src, st.flo} <= UCPC_PLL_RESET[5:0];
      {st.xsusp, st.xsel} <= UCPC_XCVR_RESET[1:0];
      st.txe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign usb_core_clk = st.clk_o;
  assign core_clock_gate_on = st.gate_on;
  assign core_rx_plus = st.rxp;
  assign core_rx_minus = st.rxm;
  assign core_rx_data = st.rxd;
  assign data_plus_pin_out = st.dp_o;
  assign data_plus_pin_oe = st.dp_e;
  assign data_minus_pin_out = st.dm_o;
  assign data_minus_pin_oe = st.dm_e;
  assign data_plus_pullup_en = st.pu;
  assign data_minus_pulldown_en = st.pd;
  assign tx_plus_out = st.txp;
  assign tx_minus_out = st.txm;
  assign tx_output_enable_n = st.txe_n;
  assign xcvr_suspend = st.susp;
  // [RULE18] full speed fixed
  assign xcvr_speed = 1'b1;

  // ==========================================================
  // checks
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
    hrdata[31:8] == 24'h00_0000 && !(st.ph_rd && st.ph_addr == UCPC_OFF_PLL && hrdata[7:6] != 2'h0))
    else $error("reserved bits read nonzero");
  detach_float_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE2]
    !st.attach |=> !data_plus_pin_oe && !data_minus_pin_oe)
    else $error("data pins driven while detached");
  attach_pulls_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
    $rose(st.attach) |=> data_plus_pullup_en && data_minus_pulldown_en)
    else $error("pulls not applied on attach");
  gate_blocks_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
    !st.gate_on |=> !usb_core_clk)
    else $error("core clock passed while gated");
  pll_stop_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE7]
    !st.src[2] |-> !pll_run && !pll_ref_ext)
    else $error("pll runs with source 0xx");
  bypass_clock_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE9]
    bypass && st.gate_on && st.ext_s[1] && $stable(st.src) |=> usb_core_clk && !pll_run)
    else $error("bypass clock not passed");
  ref_select_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE11]
    st.src == UCPC_SRC_EXT |-> pll_run && pll_ref_ext)
    else $error("pin reference not selected");
  freq_field_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE15]
    pll_ref_freq_select == {pll_reg[5], pll_reg[1:0]})
    else $error("frequency field misassembled");
  gate_low_only_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE22]
    $changed(st.gate_on) |-> !$past(src_level))
    else $error("gate changed while source high");
  speed_high_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE18]
    xcvr_speed)
    else $error("speed output low");
  attach_hold_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
    st.attach |=> data_plus_pullup_en && data_minus_pulldown_en)
    else $error("pulls dropped while attached");
  bypass_no_pll_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE9]
    bypass |-> !pll_run && !pll_ref_ext)
    else $error("pll runs in bypass");
  crystal_ref_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE10]
    st.src == UCPC_SRC_CRYSTAL |-> pll_run && !pll_ref_ext)
    else $error("crystal reference not selected");
  xcvr_float_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE19]
    st.xsel |=> !data_plus_pin_oe && !data_minus_pin_oe)
    else $error("data pins driven in transceiver mode");
  tx_idle_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE17]
    !st.xsel |=> tx_output_enable_n && !xcvr_suspend)
    else $error("transceiver driven while not selected");
  // reset values are what reset itself does, so these two carry no disable
  pll_reset_val_a: assert property (@(posedge core_clk) // [RULE16]
    rst |=> pll_reg == UCPC_PLL_RESET)
    else $error("pll register reset value wrong");
  line_reset_val_a: assert property (@(posedge core_clk) // [RULE20]
    rst |=> line_reg == UCPC_LINE_RESET)
    else $error("line register reset value wrong");
endmodule // ucpc_top

// file: test/ucpc_far_model.sv
// far side model: external transceiver, pin clock and pll output
`timescale 1ns/100ps
module ucpc_far_model (
  input wire logic core_clk, // pacing clock
  input wire logic pll_run, // pll enabled by the block
  input wire logic [2:0] rx_set, // line state presented when idle
  input wire logic tx_plus_out, // driven plus
  input wire logic tx_minus_out, // driven minus
  input wire logic tx_output_enable_n, // driver on, low active
  output logic ext_usb_clock_pin, // pin clock
  output logic pll_clk_in, // pll output clock
  output logic rx_plus_in, // received plus
  output logic rx_minus_in, // received minus
  output logic rx_diff_data // received data
);
  logic [2:0] div = 3'h0;
  // ==========================================================
  // clock sources
  always @(posedge core_clk) begin
    div <= div + 3'h1;
  end
  assign ext_usb_clock_pin = div[1];
  // a stopped pll gives no clock at all
  assign pll_clk_in = pll_run & div[2];
  // ==========================================================
  // line: hears its own drive while the block transmits
  assign {rx_plus_in, rx_minus_in, rx_diff_data} = tx_output_enable_n ? rx_set :
      {tx_plus_out, tx_minus_out, tx_plus_out & ~tx_minus_out};
endmodule // ucpc_far_model

// file: test/test_usb_clock_and_phy_control.sv
// testbench: registers, clock source and gate, line and transceiver paths
`timescale 1ns/100ps
module test_usb_clock_and_phy_control
  import ucpc_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, tgl = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, rx_set = 3'h5, pll_ref_freq_select;
  logic core_tx_plus = 1'b0, core_tx_minus = 1'b0, core_tx_oe_n = 1'b1, core_suspend = 1'b0;
  logic hreadyout, hresp, ext_usb_clock_pin, pll_clk_in, pll_run, pll_ref_ext;
  logic usb_core_clk, core_clock_gate_on, core_rx_plus, core_rx_minus, core_rx_data;
  logic data_plus_pin_in, data_plus_pin_out, data_plus_pin_oe, data_minus_pin_in;
  logic data_minus_pin_out, data_minus_pin_oe, data_plus_pullup_en, data_minus_pulldown_en;
  logic rx_plus_in, rx_minus_in, rx_diff_data, tx_plus_out, tx_minus_out;
  logic tx_output_enable_n, xcvr_suspend, xcvr_speed;
  int seed = 2, errors = 0, comparisons = 0;
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) tgl <= ~tgl;
  // no external pull-up, no cable sensing
  // undriven pins wander unless pulled
  assign data_plus_pin_in = data_plus_pin_oe ? data_plus_pin_out : (data_plus_pullup_en | tgl);
  assign data_minus_pin_in = data_minus_pin_oe ? data_minus_pin_out
      : (~data_minus_pulldown_en & ~tgl);
  ucpc_top dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_usb_clock_pin, .pll_clk_in,
    .pll_run, .pll_ref_ext, .pll_ref_freq_select, .usb_core_clk, .core_clock_gate_on,
    .core_tx_plus, .core_tx_minus, .core_tx_oe_n, .core_suspend, .core_rx_plus,
    .core_rx_minus, .core_rx_data, .data_plus_pin_in, .data_plus_pin_out,
    .data_plus_pin_oe, .data_minus_pin_in, .data_minus_pin_out, .data_minus_pin_oe,
    .data_plus_pullup_en, .data_minus_pulldown_en, .rx_plus_in, .rx_minus_in,
    .rx_diff_data, .tx_plus_out, .tx_minus_out, .tx_output_enable_n, .xcvr_suspend,
    .xcvr_speed);
  ucpc_far_model far (.core_clk, .pll_run, .rx_set, .tx_plus_out, .tx_minus_out,
    .tx_output_enable_n, .ext_usb_clock_pin, .pll_clk_in, .rx_plus_in, .rx_minus_in,
    .rx_diff_data);
  // ==========================================================
  // tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // single ahb word transfer: each phase held until hready is seen high at a rising edge;
  // read data is taken at the edge that ends the data phase
  task xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {28'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
      @(posedge core_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
      @(posedge core_clk);
    rd = hrdata;
  endtask
  task settle;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task clk_highs(output int n);
    n = 0;
    repeat (40) begin
      @(negedge core_clk);
      n += int'(usb_core_clk === 1'b1);
    end
  endtask
  // status word: gate, pll running, bypass, pin reference
  function automatic logic [31:0] exp_status(input logic [2:0] s, input logic g);
    return {28'h0, s == UCPC_SRC_EXT, s == UCPC_SRC_BYPASS, s[2:1] == 2'h3, g};
  endfunction
  // line levels as heard back: plus, minus, differential data
  function automatic logic [2:0] exp_line(input logic p, input logic m);
    return {p, m, p & ~m};
  endfunction
  task print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [2:0] src, frq;
    logic g, at;
    int n;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    xfer(UCPC_OFF_LINE, 1'b0, 32'h0);
    chk(rd, 32'h00);
    chk(32'({hreadyout, hresp}), 32'h2);
    xfer(UCPC_OFF_PLL, 1'b0, 32'h0);
    chk(rd, 32'h01);
    chk(32'(pll_ref_freq_select), 32'h1);
    xfer(UCPC_OFF_LINE, 1'b1, 32'hFFFFFFFD);
    xfer(UCPC_OFF_LINE, 1'b0, 32'h0);
    chk(rd, 32'h01);
    clk_highs(n);
    chk(32'(n), 32'h0);
    xfer(UCPC_OFF_PLL, 1'b1, 32'hFFFFFFDD);
    xfer(UCPC_OFF_PLL, 1'b0, 32'h0);
    chk(rd, 32'h1D);
    for (int i = 0; i < 24; i++) begin
      src = (i < 8) ? i[2:0] : 3'($random(seed));
      frq = (i < 5) ? i[2:0] : 3'({$random(seed)} % 5);
      if (src == 3'h4)
        src = 3'h5;
      // gate closed before the source changes
      xfer(UCPC_OFF_LINE, 1'b1, 32'h0);
      xfer(UCPC_OFF_PLL, 1'b1, {26'h0, frq[2], src, frq[1:0]});
      g = 1'($random(seed));
      at = 1'($random(seed));
      {core_tx_plus, core_tx_minus, core_tx_oe_n} <= 3'($random(seed));
      settle();
      xfer(UCPC_OFF_LINE, 1'b1, {30'h0, at, g});
      xfer(UCPC_OFF_PLL, 1'b0, 32'h0);
      chk(rd, {26'h0, frq[2], src, frq[1:0]});
      chk(32'(pll_ref_freq_select), 32'(frq));
      chk(32'(pll_run), 32'(src[2:1] == 2'h3));
      chk(32'(pll_ref_ext), 32'(src == 3'h7));
      clk_highs(n);
      chk(32'(n > 0), 32'(g & (src >= 3'h5)));
      chk(32'(data_plus_pullup_en & data_minus_pulldown_en), 32'(at));
      chk(32'(data_plus_pin_oe | data_minus_pin_oe), 32'(at & ~core_tx_oe_n));
      chk(32'({data_plus_pin_out, data_minus_pin_out}),
          32'({core_tx_plus, core_tx_minus}));
      chk(32'({tx_output_enable_n, xcvr_suspend}), 32'h2);
      if (at)
        chk(32'({core_rx_plus, core_rx_minus, core_rx_data}),
            32'(core_tx_oe_n ? 3'h5 : exp_line(core_tx_plus, core_tx_minus)));
      xfer(UCPC_OFF_STAT, 1'b0, 32'h0);
      chk(rd, exp_status(src, g));
      chk(32'(core_clock_gate_on), 32'(g));
    end
    xfer(UCPC_OFF_XCVR, 1'b1, 32'h1);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      {core_tx_plus, core_tx_minus, core_tx_oe_n} <= 3'($random(seed));
      core_suspend <= i[0];
      rx_set <= 3'($random(seed));
      // forced suspend bit toggled every other pass
      xfer(UCPC_OFF_XCVR, 1'b1, {30'h0, i[1], 1'b1});
      settle();
      chk(32'({tx_plus_out, tx_minus_out, tx_output_enable_n, xcvr_suspend}),
          32'({core_tx_plus, core_tx_minus, core_tx_oe_n, core_suspend | i[1]}));
      chk(32'(xcvr_speed), 32'h1);
      chk(32'({core_rx_plus, core_rx_minus, core_rx_data}),
          32'(core_tx_oe_n ? rx_set : exp_line(core_tx_plus, core_tx_minus)));
      chk(32'(data_plus_pin_oe | data_minus_pin_oe), 32'h0);
    end
    // mid-run reset: registers and pin controls back to their reset values
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    xfer(UCPC_OFF_LINE, 1'b0, 32'h0);
    chk(rd, 32'h00);
    xfer(UCPC_OFF_PLL, 1'b0, 32'h0);
    chk(rd, 32'h01);
    xfer(UCPC_OFF_XCVR, 1'b0, 32'h0);
    chk(rd, 32'h00);
    chk(32'({tx_output_enable_n, data_plus_pullup_en, core_clock_gate_on}), 32'h4);
    print_verdict();
  end
endmodule // test_usb_clock_and_phy_control
